// *** hdl/ssi_slave.sv ***
// two-wire / smbus slave interface with strap addressing and bus stall timeout
//
// How it works
// - in smbus mode a stuck clock or low data line for 25 ms acts as STOP
// - the mode input switches the stall timeout on (smbus) or off (plain two-wire)
// - address bits 1:0 come from decoding the low strap pin
// - address bits 3:2 come from decoding the high strap pin
// - slave only: never starts transfers, never makes START or STOP
// - clock line is input only, never driven or stretched
// - data line is open drain, released unless sending low; idle is high
// - works at 100 kbps and 400 kbps; master keeps clock at or below 400 kHz
// - pulses up to 50 ns on either line are filtered out of the protocol logic; the stall timeout uses the unfiltered lines
// - respond only when type code and strap bits match the received address
// - strap decode: ground 00, supply 01, clock 10, data 11
// - last address bit: 0 master writes, 1 slave returns data
// - refused bytes are not acknowledged: data line left high
`timescale 1ns/1ns
`default_nettype none
module ssi_slave
  import ssi_pkg::*;
#(
  parameter int         TIMEOUT_CYCLES = ssi_pkg::TIMEOUT_CYC,
  parameter logic [2:0] DEV_TYPE       = ssi_pkg::DEV_TYPE_DEF,
  parameter int         RX_DEPTH       = ssi_pkg::FIFO_DEPTH
) (
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  input  wire logic                     linkClk,
  input  wire logic                     sclIn,
  input  wire logic                     sdaIn,
  output var  logic                     sdaOut,
  output var  logic                     sdaOeN,
  input  wire logic                     addrStrapLow,
  input  wire logic                     addrStrapHigh,
  input  wire logic                     timeoutModeBit,
  input  wire logic                     engineBusy,
  output var  logic                     rxValid,
  output var  logic [ssi_pkg::RX_W-1:0] rxWord,
  input  wire logic                     rxReady,
  input  wire logic                     txValid,
  input  wire logic [7:0]               txData,
  output var  logic                     txTaken,
  output var  logic                     busStop
);
  import ssi_pkg::*;

  localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [TO_W-1:0] TO_MAX = TO_W'(TIMEOUT_CYCLES);

  // ---------------- link domain ----------------
  logic rstMeta_q;
  logic linkRst_q;
  always_ff @(posedge linkClk) begin
    rstMeta_q <= sys_rst;
    linkRst_q <= rstMeta_q;
  end

  logic [PIN_N-1:0] pinRaw;
  logic [PIN_N-1:0] pinF;
  assign pinRaw = {addrStrapHigh, addrStrapLow, sdaIn, sclIn};

  // straps share the line pipeline so a strap tied to a bus line stays aligned with it
  for (genvar g = 0; g < PIN_N; g++) begin : gPin
    logic              meta_q;
    logic              sync_q;
    logic              filt_q;
    logic [FILT_W-1:0] cnt_q;
    always_ff @(posedge linkClk) begin
      meta_q <= pinRaw[g];
      sync_q <= meta_q;
    end
    always_ff @(posedge linkClk) begin
      if (linkRst_q) begin
        filt_q <= 1'b1;
        cnt_q  <= '0;
      end else if (sync_q == filt_q) begin
        cnt_q  <= '0;
      end else if (cnt_q == FILT_LAST) begin
        filt_q <= sync_q;
        cnt_q  <= '0;
      end else begin
        cnt_q  <= cnt_q + 1'b1;
      end
    end
    assign pinF[g] = filt_q;
  end

  // crossings from mclk into the link domain
  logic [3:0] xMeta_q;
  logic [3:0] xSync_q;
  logic       toTgl_q;
  logic       txAck_q;
  logic       fifoInReady;
  logic       toSeenL_q;
  always_ff @(posedge linkClk) begin
    xMeta_q <= {toTgl_q, txAck_q, fifoInReady, engineBusy};
    xSync_q <= xMeta_q;
  end
  logic busyL;
  logic rxRoomL;
  logic txAckL;
  logic toEv;
  assign busyL   = xSync_q[0];
  assign rxRoomL = xSync_q[1];
  assign txAckL  = xSync_q[2];
  assign toEv    = xSync_q[3] != toSeenL_q;

  logic sclF;
  logic sdaF;
  logic sclP_q;
  logic sdaP_q;
  // the clock line is only ever read: no path can drive or stretch it
  assign sclF = pinF[PIN_SCL];
  assign sdaF = pinF[PIN_SDA];

  logic sclRise;
  logic sclFall;
  logic startEv;
  logic stopEv;
  assign sclRise = sclF && !sclP_q;
  assign sclFall = !sclF && sclP_q;
  assign startEv = sclF && sclP_q && sdaP_q && !sdaF;
  assign stopEv  = (sclF && sclP_q && !sdaP_q && sdaF) || toEv;

  ssi_state_t state_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shiftIn_q;
  logic [7:0] txShift_q;
  logic       acked_q;
  logic       rw_q;
  logic       mNack_q;
  logic       first_q;
  logic       txReq_q;
  logic       rxTgl_q;
  logic       stopTgl_q;
  logic [RX_W-1:0] rxHold_q;
  logic [7:0] txHold_q;
  logic [1:0] capIdle_q;
  logic [1:0] capStart_q;
  logic [1:0] capLow_q;

  // strap captures: line idle high, clock high with data low, clock low
  logic [1:0] strapNow;
  assign strapNow = {pinF[PIN_SHI], pinF[PIN_SLO]};
  always_ff @(posedge linkClk) begin
    if (linkRst_q) begin
      capIdle_q  <= '0;
      capStart_q <= '0;
      capLow_q   <= '0;
    end else begin
      if (state_q == SSI_IDLE && sclF && sdaF) capIdle_q <= strapNow;
      if (state_q == SSI_ADDR && sclF && !sdaF) capStart_q <= strapNow;
      if (state_q == SSI_ADDR && !sclF) capLow_q <= strapNow;
    end
  end

  function automatic logic [1:0] strapCode(input logic i, input logic s, input logic l);
    strapCode = !i ? STRAP_GND : (!s ? STRAP_SDA : (l ? STRAP_VCC : STRAP_SCL));
  endfunction

  logic [1:0] strapLoCode;
  logic [1:0] strapHiCode;
  assign strapLoCode = strapCode(capIdle_q[0], capStart_q[0], capLow_q[0]);
  assign strapHiCode = strapCode(capIdle_q[1], capStart_q[1], capLow_q[1]);

  logic       atAck;
  logic       ackEnd;
  logic       addrHit;
  logic       rwBit;
  logic       addrOk;
  logic       wrOk;
  logic       txAvail;
  logic [7:0] txByte;
  logic       active;
  assign atAck   = sclFall && bitCnt_q == BYTE_BITS;
  assign ackEnd  = sclFall && bitCnt_q == ACK_CNT;
  assign addrHit = shiftIn_q[7:1] == {DEV_TYPE, strapHiCode, strapLoCode};
  assign rwBit   = shiftIn_q[0];
  assign addrOk  = addrHit && !busyL && (rwBit || rxRoomL);
  assign wrOk    = !busyL && rxRoomL;
  assign txAvail = txAckL == txReq_q;
  // an empty holding register reads as released bus; a second request made before the first is served reads the old byte
  assign txByte  = txAvail ? txHold_q : TX_FILL;
  assign active  = state_q != SSI_IDLE && state_q != SSI_SKIP;

  always_ff @(posedge linkClk) begin
    if (linkRst_q) begin
      sclP_q    <= 1'b1;
      sdaP_q    <= 1'b1;
      toSeenL_q <= 1'b0;
      bitCnt_q  <= '0;
      shiftIn_q <= '0;
      mNack_q   <= 1'b1;
    end else begin
      sclP_q    <= sclF;
      sdaP_q    <= sdaF;
      toSeenL_q <= xSync_q[3];
      if (startEv || stopEv || ackEnd) bitCnt_q <= '0;
      else if (sclRise && active) bitCnt_q <= bitCnt_q + 1'b1;
      if (sclRise && bitCnt_q < BYTE_BITS) shiftIn_q <= {shiftIn_q[6:0], sdaF};
      if (sclRise && bitCnt_q == BYTE_BITS) mNack_q <= sdaF;
    end
  end

  // protocol engine: only reacts to master START/STOP, the stall timeout and clock edges
  always_ff @(posedge linkClk) begin
    if (linkRst_q) begin
      state_q   <= SSI_IDLE;
      sdaOut    <= 1'b0;
      sdaOeN    <= 1'b1;
      acked_q   <= 1'b0;
      rw_q      <= 1'b0;
      first_q   <= 1'b0;
      txReq_q   <= 1'b0;
      rxTgl_q   <= 1'b0;
      stopTgl_q <= 1'b0;
      rxHold_q  <= '0;
      txShift_q <= '0;
    end else if (stopEv) begin
      state_q   <= SSI_IDLE;
      sdaOeN    <= 1'b1;
      stopTgl_q <= !stopTgl_q;
    end else if (startEv) begin
      state_q <= SSI_ADDR;
      sdaOeN  <= 1'b1;
    end else begin
      unique case (state_q)
        SSI_IDLE, SSI_SKIP: sdaOeN <= 1'b1;
        SSI_ADDR: begin
          if (atAck) begin
            sdaOeN  <= !addrOk;
            acked_q <= addrOk;
            rw_q    <= rwBit;
            first_q <= 1'b1;
            if (addrOk && rwBit) txReq_q <= !txReq_q;
          end else if (ackEnd) begin
            if (!acked_q) begin
              state_q <= SSI_SKIP;
              sdaOeN  <= 1'b1;
            end else if (rw_q) begin
              state_q   <= SSI_READ;
              txShift_q <= txByte;
              sdaOeN    <= txByte[7];
              txReq_q   <= !txReq_q;
            end else begin
              state_q <= SSI_WRITE;
              sdaOeN  <= 1'b1;
            end
          end
        end
        SSI_WRITE: begin
          if (atAck) begin
            sdaOeN  <= !wrOk;
            acked_q <= wrOk;
            if (wrOk) begin
              rxHold_q <= {first_q, shiftIn_q};
              rxTgl_q  <= !rxTgl_q;
              first_q  <= 1'b0;
            end
          end else if (ackEnd) begin
            sdaOeN <= 1'b1;
            if (!acked_q) state_q <= SSI_SKIP;
          end
        end
        SSI_READ: begin
          if (atAck) begin
            sdaOeN <= 1'b1;
          end else if (ackEnd) begin
            if (mNack_q) begin
              state_q <= SSI_SKIP;
              sdaOeN  <= 1'b1;
            end else begin
              txShift_q <= txByte;
              sdaOeN    <= txByte[7];
              txReq_q   <= !txReq_q;
            end
          end else if (sclFall && bitCnt_q != '0 && bitCnt_q < BYTE_BITS) begin
            txShift_q <= {txShift_q[6:0], 1'b0};
            sdaOeN    <= txShift_q[6];
          end
        end
        default: begin
          state_q <= SSI_IDLE;
          sdaOeN  <= 1'b1;
        end
      endcase
    end
  end

  // ---------------- mclk domain ----------------
  logic [2:0] lMeta_q;
  logic [2:0] lSync_q;
  logic [2:0] lPrev_q;
  always_ff @(posedge mclk) begin
    lMeta_q <= {stopTgl_q, txReq_q, rxTgl_q};
    lSync_q <= lMeta_q;
  end

  logic rxNew;
  logic txPend;
  logic stopNew;
  assign rxNew   = lSync_q[0] != lPrev_q[0];
  assign txPend  = lSync_q[1] != txAck_q;
  assign stopNew = lSync_q[2] != lPrev_q[2];

  // rxHold is stable for a whole byte time once its toggle is seen
  ssi_fifo #(
    .WIDTH (RX_W),
    .DEPTH (RX_DEPTH)
  ) uRxFifo (
    .clk      (mclk),
    .rst      (sys_rst),
    .inValid  (rxNew),
    .inData   (rxHold_q),
    .inReady  (fifoInReady),
    .outValid (rxValid),
    .outData  (rxWord),
    .outReady (rxReady)
  );

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lPrev_q  <= '0;
      txAck_q  <= 1'b0;
      txHold_q <= '0;
      txTaken  <= 1'b0;
      busStop  <= 1'b0;
    end else begin
      lPrev_q <= lSync_q;
      txTaken <= txPend && txValid;
      busStop <= stopNew;
      if (txPend && txValid) begin
        txHold_q <= txData;
        txAck_q  <= !txAck_q;
      end
    end
  end

  // stall timeout watches the raw lines on mclk
  logic sclMeta_q;
  logic sclM_q;
  logic sclMP_q;
  logic sdaMeta_q;
  logic sdaM_q;
  always_ff @(posedge mclk) begin
    sclMeta_q <= sclIn;
    sclM_q    <= sclMeta_q;
    sdaMeta_q <= sdaIn;
    sdaM_q    <= sdaMeta_q;
  end

  logic [TO_W-1:0] sclStill_q;
  logic [TO_W-1:0] sdaLow_q;
  logic [TO_W-1:0] sclStill_d;
  logic [TO_W-1:0] sdaLow_d;
  logic            toHit;
  assign sclStill_d = (sclM_q != sclMP_q) ? '0 :
                      (sclStill_q == TO_MAX) ? sclStill_q : sclStill_q + 1'b1;
  assign sdaLow_d   = sdaM_q ? '0 : (sdaLow_q == TO_MAX) ? sdaLow_q : sdaLow_q + 1'b1;
  // fires once per stall even when both watches run out a few cycles apart
  assign toHit = timeoutModeBit &&
                 (sclStill_d == TO_MAX || sdaLow_d == TO_MAX) &&
                 !(sclStill_q == TO_MAX || sdaLow_q == TO_MAX);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sclMP_q    <= 1'b1;
      sclStill_q <= '0;
      sdaLow_q   <= '0;
      toTgl_q    <= 1'b0;
    end else begin
      sclMP_q    <= sclM_q;
      sclStill_q <= sclStill_d;
      sdaLow_q   <= sdaLow_d;
      if (toHit) toTgl_q <= !toTgl_q;
    end
  end
endmodule // ssi_slave
`default_nettype wire

// *** hdl/ssi_pkg.sv ***
// shared constants and types of the smbus slave interface
package ssi_pkg;
  // clock rates in ns per cycle
  localparam int CLK_NS    = 100;
  localparam int LINK_NS   = 64;
  localparam int NS_PER_MS = 1000000;

  // spike filter: glitches up to this width never reach the protocol logic
  localparam int SPIKE_NS  = 50;
  localparam int SPIKE_CYC = (SPIKE_NS + LINK_NS - 1) / LINK_NS;
  localparam int FILT_W    = 2;
  localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(SPIKE_CYC);

  // bus stall interval, counted on mclk; the shortest legal value is used
  localparam int TIMEOUT_MIN_MS = 25;
  localparam int TIMEOUT_MAX_MS = 75;
  localparam int TIMEOUT_CYC    = (TIMEOUT_MIN_MS * NS_PER_MS + CLK_NS - 1) / CLK_NS;

  // device-type code: value is arbitrary
  localparam logic [2:0] DEV_TYPE_DEF = 3'h3;

  // strap decode: tied to ground, supply, clock line, data line
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_VCC = 2'h1;
  localparam logic [1:0] STRAP_SCL = 2'h2;
  localparam logic [1:0] STRAP_SDA = 2'h3;

  // bit counting within a byte
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_CNT   = 4'h9;
  localparam logic [7:0] TX_FILL   = 8'hff;

  // receive fifo word: first-after-address flag above the byte
  localparam int RX_W       = 9;
  localparam int RX_FIRST   = 8;
  localparam int FIFO_DEPTH = 4;

  // pin index within the filtered group
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_SLO = 2;
  localparam int PIN_SHI = 3;
  localparam int PIN_N   = 4;

  typedef enum logic [2:0] {
    SSI_IDLE  = 3'b000,
    SSI_ADDR  = 3'b001,
    SSI_WRITE = 3'b010,
    SSI_READ  = 3'b011,
    SSI_SKIP  = 3'b100
  } ssi_state_t;
endpackage

// *** hdl/ssi_fifo.sv ***
// small synchronous fifo with registered outputs
`timescale 1ns/1ns
`default_nettype none
module ssi_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output var  logic             inReady,
  output var  logic             outValid,
  output var  logic [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wrPtr_q;
  logic [PW-1:0]    rdPtr_q;
  logic [CW-1:0]    count_q;
  logic             push;
  logic             pop;
  logic [PW-1:0]    rdPtr_d;
  logic [CW-1:0]    count_d;
  logic [CW-1:0]    left;
  logic [WIDTH-1:0] head_d;

  assign push    = inValid && inReady;
  assign pop     = outReady && outValid;
  assign rdPtr_d = pop ? PW'((rdPtr_q + 1'b1) % DEPTH) : rdPtr_q;
  assign left    = count_q - CW'(pop);
  assign count_d = left + CW'(push);
  // a word written into an empty queue falls straight through to the head
  assign head_d  = (left == '0) ? inData : mem_q[rdPtr_d];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_q  <= '0;
      rdPtr_q  <= '0;
      count_q  <= '0;
      inReady  <= 1'b0;
      outValid <= 1'b0;
      outData  <= '0;
    end else begin
      wrPtr_q  <= push ? PW'((wrPtr_q + 1'b1) % DEPTH) : wrPtr_q;
      rdPtr_q  <= rdPtr_d;
      count_q  <= count_d;
      inReady  <= count_d != FULL;
      outValid <= count_d != '0;
      outData  <= head_d;
    end
  end
endmodule // ssi_fifo
`default_nettype wire

// *** testbench/ssi_slave_props.sv ***
// port checker for the smbus slave interface
`timescale 1ns/1ns
`default_nettype none
module ssi_slave_props
  import ssi_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = 600
) (
  input wire logic                     mclk,
  input wire logic                     sys_rst,
  input wire logic                     linkClk,
  input wire logic                     sclIn,
  input wire logic                     sdaIn,
  input wire logic                     sdaOut,
  input wire logic                     sdaOeN,
  input wire logic                     timeoutModeBit,
  input wire logic                     rxValid,
  input wire logic [ssi_pkg::RX_W-1:0] rxWord,
  input wire logic                     rxReady,
  input wire logic                     txTaken,
  input wire logic                     busStop
);
  // slack covers the mclk line sync and the crossings into the link domain and back
  localparam int STALL_MAX = TIMEOUT_CYCLES + 24;
  int sdaStall_q;
  int sclStall_q;
  int sdaStall_d;
  int sclStall_d;
  assign sdaStall_d = (!timeoutModeBit || sdaIn || busStop) ? 0 : sdaStall_q + 1;
  assign sclStall_d = (!timeoutModeBit || sclIn || busStop) ? 0 : sclStall_q + 1;
  always_ff @(posedge mclk) begin
    sdaStall_q <= sys_rst ? 0 : sdaStall_d;
    sclStall_q <= sys_rst ? 0 : sclStall_d;
  end

  property p_odOut;
    @(posedge linkClk) disable iff (sys_rst) sdaOut == 1'b0;
  endproperty
  a_odOut: assert property (p_odOut) else $error("data output not low");
  property p_pullLow;
    @(posedge linkClk) disable iff (sys_rst) $fell(sdaOeN) |-> !sclIn;
  endproperty
  a_pullLow: assert property (p_pullLow) else $error("pulled data with clock high");
  property p_holdLow;
    @(posedge linkClk) disable iff (sys_rst) (!sdaOeN && sclIn) |=> (!sdaOeN || !sclIn);
  endproperty
  a_holdLow: assert property (p_holdLow) else $error("data moved with clock high");
  property p_oeRst;
    @(posedge linkClk) disable iff (sys_rst) $fell(sys_rst) |-> sdaOeN;
  endproperty
  a_oeRst: assert property (p_oeRst) else $error("data driven out of reset");
  property p_usrRst;
    @(posedge mclk) disable iff (sys_rst) $fell(sys_rst) |-> !rxValid && !busStop && !txTaken;
  endproperty
  a_usrRst: assert property (p_usrRst) else $error("user side busy out of reset");
  property p_stopOne;
    @(posedge mclk) disable iff (sys_rst) $rose(busStop) |=> !busStop;
  endproperty
  a_stopOne: assert property (p_stopOne) else $error("stop pulse too long");
  property p_txOne;
    @(posedge mclk) disable iff (sys_rst) $rose(txTaken) |=> !txTaken;
  endproperty
  a_txOne: assert property (p_txOne) else $error("taken pulse too long");
  property p_rxHold;
    @(posedge mclk) disable iff (sys_rst) (rxValid && !rxReady) |=> rxValid && $stable(rxWord);
  endproperty
  a_rxHold: assert property (p_rxHold) else $error("receive word lost");
  property p_sdaStall;
    @(posedge mclk) disable iff (sys_rst) sdaStall_q <= STALL_MAX;
  endproperty
  a_sdaStall: assert property (p_sdaStall) else $error("no stop after data stall");
  property p_sclStall;
    @(posedge mclk) disable iff (sys_rst) sclStall_q <= STALL_MAX;
  endproperty
  a_sclStall: assert property (p_sclStall) else $error("no stop after clock stall");

  c_stop: cover property (@(posedge mclk) busStop);
  c_tx: cover property (@(posedge mclk) txTaken);
  c_pop: cover property (@(posedge mclk) rxValid && rxReady);
  c_ack: cover property (@(posedge linkClk) $fell(sdaOeN));
endmodule // ssi_slave_props

bind ssi_slave ssi_slave_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) ssi_slave_props_inst (
  .mclk, .sys_rst, .linkClk, .sclIn, .sdaIn, .sdaOut, .sdaOeN, .timeoutModeBit,
  .rxValid, .rxWord, .rxReady, .txTaken, .busStop);
`default_nettype wire

// *** testbench/ssi_master_model.sv ***
// bus master model: drives the clock line and pulls the data line low
`timescale 1ns/1ns
`default_nettype none
module ssi_master_model (
  output var  logic scl,
  output var  logic sdaLow,
  input  wire logic sda
);
  int qns = 625;
  bit glitch = 1'b0;
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // only the master makes START and STOP; quarter bit keeps clock at or below 400 kHz
  task automatic start();
    sdaLow = 1'b0;
    #qns scl = 1'b1;
    #qns sdaLow = 1'b1;
    #qns scl = 1'b0;
  endtask
  task automatic stop();
    sdaLow = 1'b1;
    #qns scl = 1'b1;
    #qns sdaLow = 1'b0;
    #qns;
  endtask
  task automatic bitx(input logic b, output logic r);
    sdaLow = !b;
    #qns scl = 1'b1;
    #qns r = sda;
    #qns scl = 1'b0;
    if (glitch) begin
      // short spike in the low phase must not count as a clock edge
      #200 scl = 1'b1;
      #40 scl = 1'b0;
    end
    #qns;
  endtask
  task automatic wrByte(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, nack);
  endtask
  task automatic rdByte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(nack, r);
  endtask
endmodule // ssi_master_model
`default_nettype wire

// *** testbench/ssi_slave_tb_top.sv ***
// self-checking bench for the smbus slave interface
`timescale 1ns/1ns
`default_nettype none
module ssi_slave_tb_top;
  import ssi_pkg::*;
  localparam int TOC = 600;
  logic             mclk = 1'b0;
  logic             linkClk = 1'b0;
  logic             sysRst = 1'b1;
  logic             timeoutModeBit = 1'b0;
  logic             engineBusy = 1'b0;
  logic             rxReady = 1'b0;
  logic             txValid = 1'b0;
  logic [7:0]       txData = 8'h3c;
  logic [1:0]       selLo = 2'h0;
  logic [1:0]       selHi = 2'h0;
  wire logic        scl, sdaLow, sda, strapLo, strapHi;
  logic             sdaOut, sdaOeN, rxValid, txTaken, busStop;
  logic [RX_W-1:0]  rxWord;
  int               mismatches = 0;
  int               comparisons = 0;
  int               stops = 0;
  int               cyc = 0;

  always #50 mclk = ~mclk;
  always #32 linkClk = ~linkClk;
  // pull-up unless a party pulls the line low
  assign sda = ~(sdaLow | (~sdaOeN & ~sdaOut));
  function automatic logic pick(input logic [1:0] s, input logic c, input logic d);
    return (s == 2'h0) ? 1'b0 : (s == 2'h1) ? 1'b1 : (s == 2'h2) ? c : d;
  endfunction
  assign strapLo = pick(selLo, scl, sda);
  assign strapHi = pick(selHi, scl, sda);

  ssi_slave #(.TIMEOUT_CYCLES(TOC)) ssi_slave_inst (.mclk(mclk), .sys_rst(sysRst),
    .linkClk(linkClk), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
    .addrStrapLow(strapLo), .addrStrapHigh(strapHi), .timeoutModeBit(timeoutModeBit),
    .engineBusy(engineBusy), .rxValid(rxValid), .rxWord(rxWord), .rxReady(rxReady),
    .txValid(txValid), .txData(txData), .txTaken(txTaken), .busStop(busStop));
  ssi_master_model ssi_master_model_inst (.scl(scl), .sdaLow(sdaLow), .sda(sda));

  always @(posedge mclk) begin
    cyc++;
    if (busStop === 1'b1) stops++;
    if (txTaken === 1'b1) txData <= #1 txData + 8'h11;
    if (cyc == 30000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  function automatic logic [7:0] own(input logic rd);
    return {DEV_TYPE_DEF, selHi, selLo, rd};
  endfunction
  task automatic pop();
    rxReady = 1'b1;
    tick(1);
    rxReady = 1'b0;
    tick(1);
  endtask

  task automatic t_straps();
    logic a;
    for (int k = 0; k < 4; k++) begin
      selLo = 2'(k);
      selHi = 2'(3 - k);
      sysRst = 1'b1;
      // long enough for the link-side reset and both crossings to settle
      tick(8);
      sysRst = 1'b0;
      tick(20);
      ssi_master_model_inst.start();
      ssi_master_model_inst.wrByte(own(1'b0) ^ (8'h02 << k), a);
      chk(9'(a), 9'h1, "foreign address acked");
      ssi_master_model_inst.start();
      ssi_master_model_inst.wrByte(own(1'b0), a);
      chk(9'(a), 9'h0, "own address refused");
      ssi_master_model_inst.wrByte(8'hc3, a);
      ssi_master_model_inst.stop();
      tick(8);
      chk(rxWord, {1'b1, 8'hc3}, "first byte");
      pop();
    end
    $display("test straps done");
  endtask

  task automatic t_fifo();
    logic a;
    int s0;
    s0 = stops;
    ssi_master_model_inst.qns = 2500;
    ssi_master_model_inst.glitch = 1'b1;
    ssi_master_model_inst.start();
    ssi_master_model_inst.wrByte(own(1'b0), a);
    for (int i = 0; i < 5; i++) begin
      ssi_master_model_inst.wrByte(8'h10 + 8'(i), a);
      chk(9'(a), 9'(i == 4), "full fifo answer");
    end
    ssi_master_model_inst.stop();
    tick(8);
    chk(9'(stops - s0), 9'h1, "stop pulse");
    for (int i = 0; i < 4; i++) begin
      chk(rxWord, {i == 0, 8'h10 + 8'(i)}, "drained byte");
      pop();
    end
    chk(9'(rxValid), 9'h0, "fifo not empty");
    ssi_master_model_inst.qns = 625;
    ssi_master_model_inst.glitch = 1'b0;
    $display("test fifo done");
  endtask

  task automatic t_busy_read();
    logic a;
    logic [7:0] d;
    engineBusy = 1'b1;
    ssi_master_model_inst.start();
    ssi_master_model_inst.wrByte(own(1'b0), a);
    chk(9'(a), 9'h1, "busy address acked");
    ssi_master_model_inst.stop();
    tick(1);
    engineBusy = 1'b0;
    txValid = 1'b1;
    ssi_master_model_inst.start();
    ssi_master_model_inst.wrByte(own(1'b1), a);
    chk(9'(a), 9'h0, "read address refused");
    ssi_master_model_inst.rdByte(1'b0, d);
    chk(9'(d), 9'h3c, "first read byte");
    ssi_master_model_inst.rdByte(1'b1, d);
    chk(9'(d), 9'h4d, "second read byte");
    ssi_master_model_inst.stop();
    tick(1);
    txValid = 1'b0;
    $display("test busy and read done");
  endtask

  task automatic t_timeout();
    logic a;
    logic r;
    int s0;
    s0 = stops;
    ssi_master_model_inst.start();
    tick(2 * TOC);
    chk(9'(stops - s0), 9'h0, "stall stop in plain mode");
    ssi_master_model_inst.stop();
    tick(8);
    timeoutModeBit = 1'b1;
    s0 = stops;
    ssi_master_model_inst.start();
    ssi_master_model_inst.wrByte(own(1'b0), a);
    ssi_master_model_inst.bitx(1'b1, r);
    ssi_master_model_inst.bitx(1'b0, r);
    tick(TOC * 3 / 2);
    chk(9'(stops - s0), 9'h1, "no stall stop");
    ssi_master_model_inst.stop();
    tick(8);
    chk(9'(rxValid), 9'h0, "partial byte delivered");
    timeoutModeBit = 1'b0;
    $display("test timeout done");
  endtask

  initial begin
    t_straps();
    t_fifo();
    t_busy_read();
    t_timeout();
    complete_run();
  end
endmodule // ssi_slave_tb_top
`default_nettype wire
